//--- src/lefm_map.svh
// register offsets, field positions, reset values and timing figures of the ecc fault manager
`ifndef LEFM_MAP_SVH
`define LEFM_MAP_SVH

// memory organisation and code geometry
`define LEFM_BANKS 8
`define LEFM_BANK_W 3
`define LEFM_DATA_W 32
`define LEFM_CW_W 39
`define LEFM_PAR_N 6

// register word offsets on the register port
`define LEFM_REG_CTRL 4'h0
`define LEFM_REG_STAT 4'h1
`define LEFM_REG_IMASK 4'h2
`define LEFM_REG_FMASK 4'h3
`define LEFM_REG_FCTL 4'h4
`define LEFM_REG_FKEY 4'h5
`define LEFM_REG_FSTAT 4'h6
`define LEFM_REG_ERRADR 4'h7
// write-only test hook: flip mask for the low bits of the next stored codeword
`define LEFM_REG_EINJ 4'h8

// control register fields
`define LEFM_CTRL_ECC_LSB 0
`define LEFM_CTRL_DED_BIT 8
`define LEFM_ECC_EN_RST 8'hFF
`define LEFM_DED_EN_RST 1'h0

// event numbering: fixed ecc events, then peripheral events
`define LEFM_EV_SEC 0
`define LEFM_EV_DED 1
`define LEFM_EV_FIXED 2

// fault control fields
`define LEFM_FCTL_ACT_BIT 0
`define LEFM_FCTL_DLY_BIT 1
`define LEFM_FCTL_LEN_LSB 16
`define LEFM_FCTL_LEN_W 16
`define LEFM_ACT_RESET 1'h0
`define LEFM_ACT_PIN 1'h1

// fault status fields
`define LEFM_FSTAT_PEND_BIT 0
`define LEFM_FSTAT_PIN_BIT 1

// keyed cancel sequence
`define LEFM_KEY_W 8
`define LEFM_KEY_FIRST 8'hA5
`define LEFM_KEY_SECOND 8'h5A

// delay tick: one microsecond, counted in system clock cycles
`define LEFM_TICK_NS 1000
`define LEFM_CLK_NS 20
`define LEFM_TICK_CYC ((`LEFM_TICK_NS + `LEFM_CLK_NS - 1) / `LEFM_CLK_NS)

`endif

//--- src/lefm_pkg.sv
// types shared by the ecc fault manager modules
package lefm_pkg;

  typedef enum logic {
    LEFM_DLY_IDLE,
    LEFM_DLY_WAIT
  } lefm_dly_state_type;

  typedef logic [38:0] lefm_cw_type;

endpackage : lefm_pkg

//--- src/lefm_secded.sv
// single-error-correct double-error-detect encoder and decoder for one 32-bit word
`timescale 1ns/1ps
`include "lefm_map.svh"

module lefm_secded (
  // encode side
  input wire logic [`LEFM_DATA_W-1:0] enc_data_in,
  output lefm_pkg::lefm_cw_type enc_cw_out,
  // decode side
  input wire lefm_pkg::lefm_cw_type dec_cw_in,
  output logic [`LEFM_DATA_W-1:0] dec_data_out,
  output logic [`LEFM_DATA_W-1:0] dec_raw_out,
  output logic dec_single_out,
  output logic dec_double_out
);

  // bit 0 holds overall parity, hamming positions 1..38, powers of two are check bits
  function automatic logic is_pow2(input int pos);
    return (pos & (pos - 1)) == 0;
  endfunction : is_pow2

  function automatic logic [`LEFM_DATA_W-1:0] extract(input lefm_pkg::lefm_cw_type cw);
    logic [`LEFM_DATA_W-1:0] d;
    int k;
    d = '0;
    k = 0;
    for (int p = 1; p < `LEFM_CW_W; p++) begin
      if (!is_pow2(p)) begin
        d[k] = cw[p];
        k++;
      end
    end
    return d;
  endfunction : extract

  always_comb begin
    lefm_pkg::lefm_cw_type cw;
    int k;
    cw = '0;
    k = 0;
    for (int p = 1; p < `LEFM_CW_W; p++) begin
      if (!is_pow2(p)) begin
        cw[p] = enc_data_in[k];
        k++;
      end
    end
    for (int b = 0; b < `LEFM_PAR_N; b++) begin
      for (int p = 1; p < `LEFM_CW_W; p++) begin
        if (!is_pow2(p) && p[b]) begin
          cw[1 << b] = cw[1 << b] ^ cw[p];
        end
      end
    end
    cw[0] = ^cw[`LEFM_CW_W-1:1];
    enc_cw_out = cw;
  end

  always_comb begin
    logic [`LEFM_PAR_N-1:0] syn;
    logic odd;
    lefm_pkg::lefm_cw_type fixed;
    odd = ^dec_cw_in;
    fixed = dec_cw_in;
    syn = '0;
    for (int p = 1; p < `LEFM_CW_W; p++) begin
      if (dec_cw_in[p]) begin
        syn = syn ^ `LEFM_PAR_N'(p);
      end
    end
    dec_single_out = 1'b0;
    dec_double_out = 1'b0;
    // an odd flip count with a syndrome outside the word is beyond correction
    if (odd && (int'(syn) < `LEFM_CW_W)) begin
      dec_single_out = 1'b1;
      fixed[syn] = ~fixed[syn];
    end else if (syn != '0) begin
      dec_double_out = 1'b1;
    end
    dec_data_out = extract(fixed);
    dec_raw_out = extract(dec_cw_in);
  end

endmodule : lefm_secded

//--- src/lefm_fault_delay.sv
// delayed fault action with keyed cancel sequence
`timescale 1ns/1ps
`include "lefm_map.svh"

module lefm_fault_delay (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // fault request and configuration
  input wire logic trigger_in,
  input wire logic delay_en_in,
  input wire logic [`LEFM_FCTL_LEN_W-1:0] delay_len_in,
  // key writes
  input wire logic key_wr_in,
  input wire logic [`LEFM_KEY_W-1:0] key_data_in,
  // result
  output logic fire_out,
  output logic pending_out
);

  localparam int TICK_CYC = `LEFM_TICK_CYC;

  lefm_pkg::lefm_dly_state_type state_q, state_d;
  logic [`LEFM_FCTL_LEN_W-1:0] cnt_q, cnt_d;
  logic [$clog2(TICK_CYC)-1:0] div_q, div_d;
  logic stage_q, stage_d;
  logic tick;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    div_d = div_q;
    stage_d = stage_q;
    fire_out = 1'b0;
    tick = 1'b0;
    unique case (state_q)
      lefm_pkg::LEFM_DLY_IDLE: begin
        if (trigger_in) begin
          if (delay_en_in && delay_len_in != '0) begin
            state_d = lefm_pkg::LEFM_DLY_WAIT;
            cnt_d = delay_len_in;
            div_d = '0;
            stage_d = 1'b0;
          end else begin
            fire_out = 1'b1;
          end
        end
      end
      lefm_pkg::LEFM_DLY_WAIT: begin
        // microsecond divider runs only while an action is pending
        if (int'(div_q) == TICK_CYC - 1) begin
          div_d = '0;
          tick = 1'b1;
        end else begin
          div_d = div_q + 1'b1;
        end
        if (tick && cnt_q == `LEFM_FCTL_LEN_W'(1)) begin
          // expiry wins over a second key landing in the same cycle
          state_d = lefm_pkg::LEFM_DLY_IDLE;
          fire_out = 1'b1;
        end else begin
          if (tick) begin
            cnt_d = cnt_q - 1'b1;
          end
          if (key_wr_in) begin
            if (!stage_q && key_data_in == `LEFM_KEY_FIRST) begin
              stage_d = 1'b1;
            end else if (stage_q && key_data_in == `LEFM_KEY_SECOND) begin
              state_d = lefm_pkg::LEFM_DLY_IDLE;
              stage_d = 1'b0;
            end else begin
              stage_d = 1'b0;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= lefm_pkg::LEFM_DLY_IDLE;
      cnt_q <= '0;
      div_q <= '0;
      stage_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      div_q <= div_d;
      stage_q <= stage_d;
    end
  end

  assign pending_out = (state_q == lefm_pkg::LEFM_DLY_WAIT);

endmodule : lefm_fault_delay

//--- src/lefm_top.sv
// ecc-protected banked memory with system event controller and fault unit
//
// Operation
// - every stored word carries a secded code that is checked on each read of a bank whose protection is on
// - protection is on after reset and can be switched off per bank
// - single flipped bit is corrected on read with no stall and raises the sec event
// - a double-bit error raises an event only while that reporting is enabled
// - byte and halfword writes merge with the old word, corrected only in protected banks, before encoding
// - software may mark any event, ecc or peripheral, as a fault
// - each event can separately be enabled as a core interrupt
// - a fault either requests a device reset or toggles the fault output pin
// - the fault action may wait a delay, cancelled by a keyed write pair
// - memory is eight banks, each with its own protection enable
`timescale 1ns/1ps
`include "lefm_map.svh"

module lefm_top #(
  parameter int MEM_AW = 8,
  parameter int NPER = 6
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // memory port from system masters
  input wire logic [MEM_AW-1:0] mem_addr_in,
  input wire logic [`LEFM_DATA_W-1:0] mem_wdata_in,
  input wire logic [3:0] mem_be_in,
  input wire logic mem_wr_in,
  input wire logic mem_rd_in,
  output logic [`LEFM_DATA_W-1:0] mem_rdata_out,
  // register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // peripheral status events, same clock
  input wire logic [NPER-1:0] periph_evt_in,
  // interrupt and fault outputs
  output logic irq_out,
  output logic fault_output_pin_out,
  output logic sys_reset_req_out
);

  localparam int DEPTH = 1 << MEM_AW;
  localparam int NEV = `LEFM_EV_FIXED + NPER;

  function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] off);
    return addr == off;
  endfunction : reg_hit

  // storage and code paths
  lefm_pkg::lefm_cw_type mem_q [DEPTH];
  lefm_pkg::lefm_cw_type rd_cw, wr_cw, flip;
  logic [`LEFM_DATA_W-1:0] dec_data, dec_raw, old_data, merged;
  logic dec_single, dec_double, bank_on;
  logic [`LEFM_BANK_W-1:0] bank;

  // registers
  logic [`LEFM_BANKS-1:0] ecc_en_q, ecc_en_d;
  logic ded_en_q, ded_en_d;
  logic [NEV-1:0] stat_q, stat_d, imask_q, imask_d, fmask_q, fmask_d, evt_raw;
  logic act_q, act_d, dly_en_q, dly_en_d;
  logic [`LEFM_FCTL_LEN_W-1:0] dly_len_q, dly_len_d;
  logic [MEM_AW-1:0] err_adr_q, err_adr_d;
  logic [`LEFM_DATA_W-1:0] einj_q, einj_d;
  logic [`LEFM_DATA_W-1:0] mem_rdata_q, mem_rdata_d;
  logic [31:0] reg_rdata_q, reg_rdata_d;
  logic irq_q, irq_d, pin_q, pin_d, rst_req_q, rst_req_d;
  logic fault_trig, fire, pending, key_wr;

  assign rd_cw = mem_q[mem_addr_in];
  assign bank = mem_addr_in[MEM_AW-1 -: `LEFM_BANK_W];
  assign bank_on = ecc_en_q[bank];

  // without a way to plant flipped bits the correction path could never be exercised from outside
  assign flip = lefm_pkg::lefm_cw_type'(einj_q);

  lefm_secded u_code (
    .enc_data_in(merged),
    .enc_cw_out(wr_cw),
    .dec_cw_in(rd_cw),
    .dec_data_out(dec_data),
    .dec_raw_out(dec_raw),
    .dec_single_out(dec_single),
    .dec_double_out(dec_double)
  );

  // memory datapath: decode, merge partial writes, re-encode
  always_comb begin
    old_data = bank_on ? dec_data : dec_raw;
    merged = old_data;
    for (int b = 0; b < 4; b++) begin
      if (mem_be_in[b]) begin
        merged[8*b +: 8] = mem_wdata_in[8*b +: 8];
      end
    end
    mem_rdata_d = mem_rd_in ? old_data : mem_rdata_q;
  end

  // check bits are always written, so re-enabling a bank finds consistent words
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (mem_wr_in) begin
      mem_q[mem_addr_in] <= wr_cw ^ flip;
    end
  end

  // event sources
  always_comb begin
    logic acc;
    acc = (mem_rd_in || (mem_wr_in && mem_be_in != 4'hF)) && bank_on;
    evt_raw = '0;
    evt_raw[`LEFM_EV_SEC] = acc && dec_single;
    evt_raw[`LEFM_EV_DED] = acc && dec_double && ded_en_q;
    evt_raw[NEV-1:`LEFM_EV_FIXED] = periph_evt_in;
  end

  // configuration registers; a planted flip mask is spent by the next memory write
  always_comb begin
    ecc_en_d = ecc_en_q;
    ded_en_d = ded_en_q;
    imask_d = imask_q;
    fmask_d = fmask_q;
    act_d = act_q;
    dly_en_d = dly_en_q;
    dly_len_d = dly_len_q;
    einj_d = einj_q;
    if (mem_wr_in) begin
      einj_d = '0;
    end
    if (reg_wr_in) begin
      if (reg_hit(reg_addr_in, `LEFM_REG_CTRL)) begin
        ecc_en_d = reg_wdata_in[`LEFM_CTRL_ECC_LSB +: `LEFM_BANKS];
        ded_en_d = reg_wdata_in[`LEFM_CTRL_DED_BIT];
      end
      if (reg_hit(reg_addr_in, `LEFM_REG_EINJ)) begin
        einj_d = reg_wdata_in;
      end
      if (reg_hit(reg_addr_in, `LEFM_REG_IMASK)) begin
        imask_d = reg_wdata_in[NEV-1:0];
      end
      if (reg_hit(reg_addr_in, `LEFM_REG_FMASK)) begin
        fmask_d = reg_wdata_in[NEV-1:0];
      end
      if (reg_hit(reg_addr_in, `LEFM_REG_FCTL)) begin
        act_d = reg_wdata_in[`LEFM_FCTL_ACT_BIT];
        dly_en_d = reg_wdata_in[`LEFM_FCTL_DLY_BIT];
        dly_len_d = reg_wdata_in[`LEFM_FCTL_LEN_LSB +: `LEFM_FCTL_LEN_W];
      end
    end
  end

  // status, error address and interrupt
  always_comb begin
    logic [NEV-1:0] w1c;
    w1c = '0;
    err_adr_d = err_adr_q;
    if (reg_wr_in && reg_hit(reg_addr_in, `LEFM_REG_STAT)) begin
      w1c = reg_wdata_in[NEV-1:0];
    end
    if (evt_raw[`LEFM_EV_SEC] || evt_raw[`LEFM_EV_DED]) begin
      err_adr_d = mem_addr_in;
    end
    // a new event in the clearing cycle survives the clear
    stat_d = (stat_q & ~w1c) | evt_raw;
    irq_d = |(stat_d & imask_d);
    fault_trig = |(evt_raw & fmask_q);
  end

  assign key_wr = reg_wr_in && reg_hit(reg_addr_in, `LEFM_REG_FKEY);

  lefm_fault_delay u_delay (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .trigger_in(fault_trig),
    .delay_en_in(dly_en_q),
    .delay_len_in(dly_len_q),
    .key_wr_in(key_wr),
    .key_data_in(reg_wdata_in[`LEFM_KEY_W-1:0]),
    .fire_out(fire),
    .pending_out(pending)
  );

  // fault action
  always_comb begin
    pin_d = pin_q;
    rst_req_d = 1'b0;
    if (fire) begin
      if (act_q == `LEFM_ACT_PIN) begin
        pin_d = ~pin_q;
      end else begin
        rst_req_d = 1'b1;
      end
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    reg_rdata_d = '0;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `LEFM_REG_CTRL: begin
          reg_rdata_d[`LEFM_CTRL_ECC_LSB +: `LEFM_BANKS] = ecc_en_q;
          reg_rdata_d[`LEFM_CTRL_DED_BIT] = ded_en_q;
        end
        `LEFM_REG_STAT: reg_rdata_d[NEV-1:0] = stat_q;
        `LEFM_REG_IMASK: reg_rdata_d[NEV-1:0] = imask_q;
        `LEFM_REG_FMASK: reg_rdata_d[NEV-1:0] = fmask_q;
        `LEFM_REG_FCTL: begin
          reg_rdata_d[`LEFM_FCTL_ACT_BIT] = act_q;
          reg_rdata_d[`LEFM_FCTL_DLY_BIT] = dly_en_q;
          reg_rdata_d[`LEFM_FCTL_LEN_LSB +: `LEFM_FCTL_LEN_W] = dly_len_q;
        end
        `LEFM_REG_FSTAT: begin
          reg_rdata_d[`LEFM_FSTAT_PEND_BIT] = pending;
          reg_rdata_d[`LEFM_FSTAT_PIN_BIT] = pin_q;
        end
        `LEFM_REG_ERRADR: reg_rdata_d[MEM_AW-1:0] = err_adr_q;
        // write-only like the key register, so a stray read cannot reveal a planted fault
        `LEFM_REG_EINJ: reg_rdata_d = '0;
        default: reg_rdata_d = '0;
      endcase
    end
  end

  // configuration group
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ecc_en_q <= `LEFM_ECC_EN_RST;
      ded_en_q <= `LEFM_DED_EN_RST;
      imask_q <= '0;
      fmask_q <= '0;
      act_q <= `LEFM_ACT_RESET;
      dly_en_q <= 1'b0;
      dly_len_q <= '0;
      einj_q <= '0;
    end else begin
      ecc_en_q <= ecc_en_d;
      ded_en_q <= ded_en_d;
      imask_q <= imask_d;
      fmask_q <= fmask_d;
      act_q <= act_d;
      dly_en_q <= dly_en_d;
      dly_len_q <= dly_len_d;
      einj_q <= einj_d;
    end
  end

  // status group
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stat_q <= '0;
      err_adr_q <= '0;
      irq_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      err_adr_q <= err_adr_d;
      irq_q <= irq_d;
    end
  end

  // fault action group
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_q <= 1'b0;
      rst_req_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
      rst_req_q <= rst_req_d;
    end
  end

  // read data group
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mem_rdata_q <= '0;
      reg_rdata_q <= '0;
    end else begin
      mem_rdata_q <= mem_rdata_d;
      reg_rdata_q <= reg_rdata_d;
    end
  end

  assign mem_rdata_out = mem_rdata_q;
  assign reg_rdata_out = reg_rdata_q;
  assign irq_out = irq_q;
  assign fault_output_pin_out = pin_q;
  assign sys_reset_req_out = rst_req_q;

endmodule : lefm_top

//--- verif/lefm_props.sv
// port checker for the ecc fault manager
`timescale 1ns/1ps
`include "lefm_map.svh"
module lefm_props #(
  parameter int MEM_AW = 8,
  parameter int NPER = 6
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // memory and register ports
  input wire logic mem_rd_in,
  input wire logic [`LEFM_DATA_W-1:0] mem_rdata_out,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // events and outputs
  input wire logic [NPER-1:0] periph_evt_in,
  input wire logic irq_out,
  input wire logic fault_output_pin_out,
  input wire logic sys_reset_req_out
);
  logic [NPER+1:0] imask_q;
  logic [NPER+1:0] fmask_q;
  logic [1:0] fctl_q;
  logic dly_q;
  logic [NPER+1:0] ev_w;
  assign ev_w = {periph_evt_in, 2'b00};
  // shadows of the masks; once a delay was used the pending state is unknown here
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      imask_q <= '0;
      fmask_q <= '0;
      fctl_q <= 2'b00;
      dly_q <= 1'b0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `LEFM_REG_IMASK) imask_q <= reg_wdata_in[NPER+1:0];
      if (reg_addr_in == `LEFM_REG_FMASK) fmask_q <= reg_wdata_in[NPER+1:0];
      if (reg_addr_in == `LEFM_REG_FCTL) fctl_q <= reg_wdata_in[1:0];
      if (reg_addr_in == `LEFM_REG_FCTL) dly_q <= dly_q | reg_wdata_in[1];
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  rdata_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
    else $error("register read data not zero when idle");
  unmapped_zero_a: assert property (reg_rd_in && reg_addr_in[3] |=> reg_rdata_out == 32'h0)
    else $error("unmapped register read not zero");
  rst_pulse_a: assert property (sys_reset_req_out |=> !sys_reset_req_out)
    else $error("reset request longer than one cycle");
  mem_hold_a: assert property (!mem_rd_in |=> $stable(mem_rdata_out))
    else $error("memory read data changed without a read");
  reset_quiet_a: assert property ($fell(rst_in) |-> !irq_out && !sys_reset_req_out)
    else $error("outputs active right after reset");
  irq_event_a: assert property (!reg_wr_in && (ev_w & imask_q) != 0 |=> irq_out)
    else $error("unmasked event gave no interrupt");
  pin_fault_a: assert property (!reg_wr_in && !dly_q && fctl_q == 2'b01
    && (ev_w & fmask_q) != 0 |=> $changed(fault_output_pin_out))
    else $error("fault did not toggle the pin");
  rst_fault_a: assert property (!reg_wr_in && !dly_q && fctl_q == 2'b00
    && (ev_w & fmask_q) != 0 |=> sys_reset_req_out)
    else $error("fault did not request reset");
endmodule : lefm_props

bind lefm_top lefm_props #(.MEM_AW(MEM_AW), .NPER(NPER)) u_props (.clk_in, .rst_in,
  .mem_rd_in, .mem_rdata_out, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
  .reg_rdata_out, .periph_evt_in, .irq_out, .fault_output_pin_out, .sys_reset_req_out);

//--- verif/lefm_master.sv
// system bus master model on the memory port
`timescale 1ns/1ps
module lefm_master #(
  parameter int MEM_AW = 8
) (
  // clock
  input wire logic clk_in,
  // memory port
  output logic [MEM_AW-1:0] mem_addr_out,
  output logic [31:0] mem_wdata_out,
  output logic [3:0] mem_be_out,
  output logic mem_wr_out,
  output logic mem_rd_out,
  input wire logic [31:0] mem_rdata_in
);
  initial begin
    mem_addr_out = '0;
    mem_wdata_out = 32'h0;
    mem_be_out = 4'h0;
    mem_wr_out = 1'b0;
    mem_rd_out = 1'b0;
  end
  task automatic wr_word(input logic [MEM_AW-1:0] a, input logic [31:0] d,
      input logic [3:0] b);
    @(posedge clk_in);
    mem_addr_out <= a;
    mem_wdata_out <= d;
    mem_be_out <= b;
    mem_wr_out <= 1'b1;
    @(posedge clk_in);
    mem_wr_out <= 1'b0;
    // released data must not look like the last write
    mem_wdata_out <= ~d;
  endtask : wr_word
  task automatic rd_word(input logic [MEM_AW-1:0] a, output logic [31:0] d);
    @(posedge clk_in);
    mem_addr_out <= a;
    mem_rd_out <= 1'b1;
    @(posedge clk_in);
    mem_rd_out <= 1'b0;
    #1 d = mem_rdata_in;
  endtask : rd_word
endmodule : lefm_master

//--- verif/lefm_top_bench.sv
// register and memory tests of the ecc fault manager
`timescale 1ns/1ps
`include "lefm_map.svh"
module lefm_top_bench;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [5:0] periph_evt_in = 6'h00;
  logic [7:0] mem_addr;
  logic [31:0] mem_wdata;
  logic [3:0] mem_be;
  logic mem_wr;
  logic mem_rd;
  logic [31:0] mem_rdata;
  logic [31:0] reg_rdata_out;
  logic irq_out;
  logic pin;
  logic sys_reset_req_out;
  logic r;
  logic [31:0] d;
  int mismatches = 0;
  int n_checks = 0;
  always #10 clk_in = ~clk_in;
  lefm_top #(.MEM_AW(8), .NPER(6)) dut (.clk_in(clk_in), .rst_in(rst_in),
    .mem_addr_in(mem_addr), .mem_wdata_in(mem_wdata), .mem_be_in(mem_be),
    .mem_wr_in(mem_wr), .mem_rd_in(mem_rd), .mem_rdata_out(mem_rdata),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .periph_evt_in(periph_evt_in),
    .irq_out(irq_out), .fault_output_pin_out(pin), .sys_reset_req_out(sys_reset_req_out));
  lefm_master #(.MEM_AW(8)) u_m (.clk_in(clk_in), .mem_addr_out(mem_addr),
    .mem_wdata_out(mem_wdata), .mem_be_out(mem_be), .mem_wr_out(mem_wr),
    .mem_rd_out(mem_rd), .mem_rdata_in(mem_rdata));
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic reg_w(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask : reg_w
  task automatic rchk(input string n, input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 check(n, reg_rdata_out, e);
  endtask : rchk
  task automatic mchk(input logic [7:0] a, input logic [31:0] e);
    u_m.rd_word(a, d);
    check("mem", d, e);
  endtask : mchk
  task automatic ev(input int i);
    @(posedge clk_in);
    periph_evt_in[i] <= 1'b1;
    @(posedge clk_in);
    periph_evt_in[i] <= 1'b0;
    #1 r = sys_reset_req_out;
  endtask : ev
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  // the tests take well under a thousand cycles
  initial begin
    #200000;
    mismatches++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    rchk("ctrl", `LEFM_REG_CTRL, 32'h000000FF);
    rchk("fctl", `LEFM_REG_FCTL, 32'h00000000);
    rchk("unmapped", 4'h9, 32'h00000000);
    $display("test reset done");
    for (int b = 0; b < 8; b++) u_m.wr_word({b[2:0], 5'h01}, 32'h12345600 + b, 4'hF);
    for (int b = 0; b < 8; b++) mchk({b[2:0], 5'h01}, 32'h12345600 + b);
    u_m.wr_word(8'h21, 32'h000000EE, 4'h1);
    u_m.wr_word(8'h21, 32'hBEEF0000, 4'hC);
    mchk(8'h21, 32'hBEEF56EE);
    reg_w(`LEFM_REG_CTRL, 32'h000001F7);
    rchk("ctrl off", `LEFM_REG_CTRL, 32'h000001F7);
    u_m.wr_word(8'h61, 32'h000000A1, 4'h1);
    mchk(8'h61, 32'h123456A1);
    $display("test memory done");
    reg_w(`LEFM_REG_EINJ, 32'h00000008);
    u_m.wr_word(8'h02, 32'hCAFE0001, 4'hF);
    mchk(8'h02, 32'hCAFE0001);
    rchk("sec", `LEFM_REG_STAT, 32'h00000001);
    rchk("erradr", `LEFM_REG_ERRADR, 32'h00000002);
    reg_w(`LEFM_REG_EINJ, 32'h00000008);
    u_m.wr_word(8'h62, 32'hCAFE0001, 4'hF);
    mchk(8'h62, 32'hCAFE0000);
    reg_w(`LEFM_REG_EINJ, 32'h00000018);
    u_m.wr_word(8'h03, 32'hCAFE0003, 4'hF);
    u_m.rd_word(8'h03, d);
    rchk("ded", `LEFM_REG_STAT, 32'h00000003);
    reg_w(`LEFM_REG_CTRL, 32'h000000F7);
    reg_w(`LEFM_REG_STAT, 32'h00000003);
    u_m.rd_word(8'h03, d);
    rchk("ded off", `LEFM_REG_STAT, 32'h00000000);
    $display("test ecc done");
    reg_w(`LEFM_REG_IMASK, 32'h00000004);
    ev(0);
    @(posedge clk_in);
    #1 check("irq", irq_out, 1'b1);
    ev(1);
    rchk("stat", `LEFM_REG_STAT, 32'h0000000C);
    reg_w(`LEFM_REG_STAT, 32'h00000004);
    @(posedge clk_in);
    #1 check("irq clear", irq_out, 1'b0);
    rchk("stat w1c", `LEFM_REG_STAT, 32'h00000008);
    $display("test events done");
    reg_w(`LEFM_REG_FMASK, 32'h00000010);
    reg_w(`LEFM_REG_FCTL, 32'h00000001);
    ev(2);
    @(posedge clk_in);
    #1 check("pin", pin, 1'b1);
    rchk("fstat", `LEFM_REG_FSTAT, 32'h00000002);
    reg_w(`LEFM_REG_FCTL, 32'h00000000);
    ev(2);
    check("reset pulse", r, 1'b1);
    $display("test fault done");
    reg_w(`LEFM_REG_FCTL, 32'h00010003);
    ev(2);
    rchk("pending", `LEFM_REG_FSTAT, 32'h00000003);
    reg_w(`LEFM_REG_FKEY, {24'h0, `LEFM_KEY_FIRST});
    reg_w(`LEFM_REG_FKEY, {24'h0, `LEFM_KEY_SECOND});
    rchk("cancel", `LEFM_REG_FSTAT, 32'h00000002);
    repeat (60) @(posedge clk_in);
    #1 check("pin kept", pin, 1'b1);
    ev(2);
    reg_w(`LEFM_REG_FKEY, {24'h0, `LEFM_KEY_FIRST});
    reg_w(`LEFM_REG_FKEY, 32'h00000033);
    reg_w(`LEFM_REG_FKEY, {24'h0, `LEFM_KEY_SECOND});
    repeat (60) @(posedge clk_in);
    #1 check("wrong key", pin, 1'b0);
    ev(2);
    repeat (56) @(posedge clk_in);
    reg_w(`LEFM_REG_FKEY, {24'h0, `LEFM_KEY_FIRST});
    reg_w(`LEFM_REG_FKEY, {24'h0, `LEFM_KEY_SECOND});
    rchk("late key", `LEFM_REG_FSTAT, 32'h00000002);
    $display("test delay done");
    test_done();
  end
endmodule : lefm_top_bench
